// >>> hdl/scd_pkg.sv
// Constants, carriers and strap decoding for the strap configuration decoder
package scd_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int LED_CLK_HZ = 1_000_000;
   localparam int LED_PERIOD_NORM_MS = 50;
   localparam int LED_PERIOD_FAST_MS = 1;
   localparam int EE_NORM_HZ = 78_125;
   localparam int EE_FAST_KHZ = 2_778;
   localparam int LED_HALF_CYC = CLK_HZ / (2 * LED_CLK_HZ);
   localparam int LED_PERIOD_NORM_CYC = (CLK_HZ / 1000) * LED_PERIOD_NORM_MS;
   localparam int LED_PERIOD_FAST_CYC = (CLK_HZ / 1000) * LED_PERIOD_FAST_MS;
   localparam int EE_NORM_HALF_CYC = CLK_HZ / (2 * EE_NORM_HZ);
   localparam int EE_FAST_HALF_CYC = CLK_HZ / (2 * EE_FAST_KHZ * 1000);
   localparam int LED_GROUP_BITS = 10;
   localparam int LED_GROUPS = 3;
   localparam int LED_FRAME_BITS = LED_GROUP_BITS * LED_GROUPS;
   localparam int LED_BURST_CYC = LED_FRAME_BITS * 2 * LED_HALF_CYC;
   localparam int NUM_PORTS = 8;
   localparam logic [5:0] COLL_PER_TRY = 6'h10;
   localparam logic [6:0] EEPROM_DEV_ADDR = 7'h51;
   // Strap bit positions
   localparam int SB_BPDU = 0;
   localparam int SB_LED_COMBINE_ACTIVITY = 1;
   localparam int SB_DROP = 2;
   localparam int SB_SRAM = 3;
   localparam int SB_INIT = 4;
   localparam int SB_RETRY = 6;
   localparam int SB_TRUNK = 16;
   localparam int SB_BP = 18;
   localparam int SB_RMII = 19;
   localparam int SB_LED_GROUP_ENABLE = 21;
   localparam int SB_SWAP = 25;
   localparam logic [31:0] STRAP_RST = 32'hFFFFFFFF;
   localparam logic [1:0] INIT_STRAPS = 2'h3;
   localparam logic [1:0] INIT_EEPROM = 2'h2;
   localparam logic [1:0] INIT_CPU = 2'h1;
   localparam logic [1:0] INIT_EE_FAST = 2'h0;
   localparam logic [1:0] RETRY_FOREVER = 2'h1;
   localparam logic [1:0] RMII_FORCE_OFF = 2'h2;
   localparam logic [1:0] RMII_FORCE_ON = 2'h1;
   // Buffer settings per memory size
   localparam logic [7:0] FREE_CNT_128K = 8'h40;
   localparam logic [7:0] RESUME_128K = 8'h2B;
   localparam logic [2:0] PRIV_128K = 3'h1;
   localparam logic [4:0] MIN_PAUSE_128K = 5'h0F;
   localparam logic [7:0] FREE_CNT_256K = 8'h95;
   localparam logic [7:0] RESUME_256K = 8'h62;
   localparam logic [2:0] PRIV_256K = 3'h4;
   localparam logic [4:0] MIN_PAUSE_256K = 5'h1C;
   localparam logic [3:0] FREE_MARGIN = 4'hA;
   // Register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STRAP = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_BUF = 8'h0C;
   localparam logic [1:0] CTRL_RST = 2'h0;

   typedef struct packed {
      logic [7:0] free_buffer_count;
      logic [7:0] resume_threshold;
      logic [2:0] private_buf_size;
      logic [3:0] free_margin;
      logic [4:0] min_pause_const_threshold;
   } scd_buf_t;

   typedef struct packed {
      logic eeprom_sel;
      logic bpdu_broadcast_sel;
      logic led_combine_activity;
      logic drop_en;
      logic sram_64k;
      logic init_straps_only;
      logic init_eeprom;
      logic init_cpu;
      logic speedup;
      logic [1:0] collision_retry_sel;
      logic retry_forever;
      logic [1:0] trunk_en;
      logic bp_en;
      logic [1:0] rmii_pause_policy;
      logic phy_adv_pause;
      logic poll_partner;
      logic [2:0] led_group_enable;
      scd_buf_t bufs;
   } scd_cfg_t;

   typedef struct packed {
      logic [7:0] fc_en;
      logic [7:0] drop_win;
      logic [7:0] ign_pause_resume;
      logic [7:0] skip_poll;
      logic [7:0] force_fd100;
      logic [7:0] drop_pkt;
   } scd_port_t;

   function automatic scd_cfg_t scd_decode(input logic [31:0] sb);
      scd_cfg_t c;
      logic [1:0] init;
      logic [1:0] rmii;
      c = '0;
      init = sb[SB_INIT +: 2];
      rmii = sb[SB_RMII +: 2];
      c.eeprom_sel = sb[SB_SWAP];
      c.bpdu_broadcast_sel = sb[SB_BPDU];
      c.led_combine_activity = sb[SB_LED_COMBINE_ACTIVITY];
      c.drop_en = sb[SB_DROP];
      c.sram_64k = sb[SB_SRAM];
      c.init_straps_only = (init == INIT_STRAPS);
      c.init_eeprom = (init == INIT_EEPROM) || (init == INIT_EE_FAST);
      c.init_cpu = (init == INIT_CPU);
      c.speedup = (init == INIT_EE_FAST);
      c.collision_retry_sel = sb[SB_RETRY +: 2];
      c.retry_forever = (sb[SB_RETRY +: 2] == RETRY_FOREVER);
      c.trunk_en = ~sb[SB_TRUNK +: 2];
      c.bp_en = sb[SB_BP];
      c.rmii_pause_policy = rmii;
      c.phy_adv_pause = (rmii != RMII_FORCE_OFF);
      c.poll_partner = (rmii != RMII_FORCE_OFF) && (rmii != RMII_FORCE_ON);
      c.led_group_enable = sb[SB_LED_GROUP_ENABLE +: 3];
      if (sb[SB_SRAM]) begin
         c.bufs = '{FREE_CNT_256K, RESUME_256K, PRIV_256K, FREE_MARGIN, MIN_PAUSE_256K};
      end else begin
         c.bufs = '{FREE_CNT_128K, RESUME_128K, PRIV_128K, FREE_MARGIN, MIN_PAUSE_128K};
      end
      return c;
   endfunction : scd_decode

   localparam scd_cfg_t CFG_RST = scd_decode(STRAP_RST);
endpackage : scd_pkg

// >>> hdl/scd_strap_config_decoder.sv
// Strap capture, decoded configuration, shared EEPROM/LED pins and per-port policy
`timescale 1ns/10ps
`default_nettype none
module scd_strap_config_decoder #(
   parameter int LED_PERIOD_NORM = scd_pkg::LED_PERIOD_NORM_CYC,
   parameter int LED_PERIOD_FAST = scd_pkg::LED_PERIOD_FAST_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Strap pins
   input wire logic [31:0] i_sram_data_bus,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   // Port status from MACs and PHY polling
   input wire logic [7:0] i_link_act,
   input wire logic [7:0] i_rxtx_evt,
   input wire logic [7:0] i_speed100,
   input wire logic [7:0] i_full_dup,
   input wire logic [7:0] i_partner_pause,
   input wire logic [7:0] i_coll_pulse,
   input wire logic [7:0] i_tx_done,
   // Shared serial pins
   output logic o_pin_clk,
   input wire logic i_pin_dat,
   output logic o_pin_dat,
   output logic o_pin_dat_oe,
   // Decoded configuration
   output scd_pkg::scd_cfg_t o_cfg,
   output logic o_cfg_valid,
   output logic o_bpdu_to_host,
   output logic o_bpdu_broadcast,
   output scd_pkg::scd_port_t o_port
);
   localparam logic [5:0] LAST_BIT = 6'(scd_pkg::LED_FRAME_BITS - 1);
   localparam logic [6:0] LED_HALF = 7'(scd_pkg::LED_HALF_CYC - 1);
   localparam logic [10:0] EE_HALF_NORM = 11'(scd_pkg::EE_NORM_HALF_CYC - 1);
   localparam logic [10:0] EE_HALF_FAST = 11'(scd_pkg::EE_FAST_HALF_CYC - 1);
   localparam logic [31:0] PER_NORM = 32'(LED_PERIOD_NORM - 1);
   localparam logic [31:0] PER_FAST = 32'(LED_PERIOD_FAST - 1);

   if (LED_PERIOD_FAST <= scd_pkg::LED_BURST_CYC || LED_PERIOD_NORM <= scd_pkg::LED_BURST_CYC)
   begin : g_period_check
      $error("LED period shorter than one LED burst");
   end

   typedef enum logic [1:0] {LED_IDLE, LED_LOW, LED_HIGH} scd_led_st_t;

   typedef struct packed {
      logic [31:0] sync1;
      logic [31:0] sync2;
      logic [31:0] sync3;
      logic [1:0] settle;
      logic captured;
      logic [31:0] strap;
      scd_pkg::scd_cfg_t cfg;
      logic [1:0] host_fwd;
      logic bpdu_to_host;
      logic bpdu_broadcast;
      logic ack;
      logic [31:0] rdat;
      logic [10:0] ee_cnt;
      logic ee_clk;
      logic [31:0] led_per;
      scd_led_st_t led_st;
      logic [6:0] led_half;
      logic [5:0] led_bit;
      logic [29:0] led_shift;
      logic led_clk;
      logic led_dat;
      logic pin_clk;
      logic pin_dat;
      logic pin_dat_oe;
      logic [7:0][5:0] coll_cnt;
      scd_pkg::scd_port_t port;
   } scd_state_t;

   scd_state_t s;
   scd_state_t next_s;

   // Flow control enable for one port under the RMII policy
   function automatic logic fc_on(input logic [1:0] pol, input logic trunk, input logic partner,
                                  input logic fdx);
      logic r;
      r = partner & fdx;
      if (trunk) begin
         r = 1'b1;
      end else if (pol == scd_pkg::RMII_FORCE_OFF) begin
         r = 1'b0;
      end else if (pol == scd_pkg::RMII_FORCE_ON) begin
         r = 1'b1;
      end
      return r;
   endfunction : fc_on

   // Group data with its mask applied
   function automatic logic [9:0] led_group(input logic en, input logic [7:0] bits);
      return en ? {2'h0, bits} : 10'h000;
   endfunction : led_group

   always_comb begin
      logic [7:0] link_view;
      logic trunk;
      logic fdx;
      logic fc;
      logic [5:0] limit;
      logic [5:0] base;
      next_s = s;
      link_view = 8'h00;
      trunk = 1'b0;
      fdx = 1'b0;
      fc = 1'b0;
      limit = 6'h00;
      base = 6'h00;

      // Three-stage pin synchroniser
      next_s.sync1 = i_sram_data_bus;
      next_s.sync2 = s.sync1;
      next_s.sync3 = s.sync2;

      // One capture after release, then frozen until the next reset
      if (!s.captured) begin
         if (s.settle != 2'h3) begin
            next_s.settle = s.settle + 2'h1;
         end else if (s.sync2 == s.sync3) begin
            next_s.strap = s.sync3;
            next_s.cfg = scd_pkg::scd_decode(s.sync3);
            next_s.captured = 1'b1;
         end
      end

      // BPDU path: host forwarding overrides the strap
      next_s.bpdu_to_host = s.host_fwd[1];
      next_s.bpdu_broadcast = ~s.host_fwd[1] & s.cfg.bpdu_broadcast_sel;

      // Wishbone classic slave, one wait state, unmapped reads zero
      next_s.ack = i_wb_cyc & i_wb_stb & ~s.ack;
      next_s.rdat = 32'h00000000;
      if (i_wb_cyc && i_wb_stb && !s.ack) begin
         if (i_wb_we && i_wb_adr == scd_pkg::REG_CTRL && i_wb_sel[0]) begin
            next_s.host_fwd = i_wb_dat[1:0];
         end
         if (!i_wb_we) begin
            unique case (i_wb_adr)
               scd_pkg::REG_CTRL: next_s.rdat = {30'h00000000, s.host_fwd};
               scd_pkg::REG_STRAP: next_s.rdat = s.strap;
               // Buffer fields are left out here; they read back through BUF
               scd_pkg::REG_STATUS: next_s.rdat = {7'h00, s.captured, 2'h0, s.cfg[49:28]};
               scd_pkg::REG_BUF: next_s.rdat = {4'h0, s.cfg.bufs};
               default: next_s.rdat = 32'h00000000;
            endcase
         end
      end

      // EEPROM clock runs only while a download is selected; idles high
      if (s.captured && s.cfg.eeprom_sel && s.cfg.init_eeprom) begin
         if (s.ee_cnt == (s.cfg.speedup ? EE_HALF_FAST : EE_HALF_NORM)) begin
            next_s.ee_cnt = 11'h000;
            next_s.ee_clk = ~s.ee_clk;
         end else begin
            next_s.ee_cnt = s.ee_cnt + 11'h001;
         end
      end else begin
         next_s.ee_cnt = 11'h000;
         next_s.ee_clk = 1'b1;
      end

      // LED frame: group 0 link view, group 1 speed, group 2 duplex
      link_view = s.cfg.led_combine_activity ? (i_link_act ^ i_rxtx_evt) : i_link_act;
      if (s.captured && !s.cfg.eeprom_sel) begin
         if (s.led_per >= (s.cfg.speedup ? PER_FAST : PER_NORM)) begin
            next_s.led_per = 32'h00000000;
         end else begin
            next_s.led_per = s.led_per + 32'h00000001;
         end
         unique case (s.led_st)
            LED_IDLE: begin
               if (s.led_per == 32'h00000000) begin
                  next_s.led_shift = {led_group(s.cfg.led_group_enable[2], i_full_dup),
                                      led_group(s.cfg.led_group_enable[1], i_speed100),
                                      led_group(s.cfg.led_group_enable[0], link_view)};
                  next_s.led_bit = 6'h00;
                  next_s.led_half = 7'h00;
                  next_s.led_st = LED_LOW;
               end
            end
            LED_LOW: begin
               next_s.led_dat = s.led_shift[0];
               if (s.led_half == LED_HALF) begin
                  next_s.led_half = 7'h00;
                  next_s.led_clk = 1'b1;
                  next_s.led_st = LED_HIGH;
               end else begin
                  next_s.led_half = s.led_half + 7'h01;
               end
            end
            LED_HIGH: begin
               if (s.led_half == LED_HALF) begin
                  next_s.led_half = 7'h00;
                  next_s.led_clk = 1'b0;
                  next_s.led_shift = {1'b0, s.led_shift[29:1]};
                  next_s.led_bit = s.led_bit + 6'h01;
                  next_s.led_st = (s.led_bit == LAST_BIT) ? LED_IDLE : LED_LOW;
               end else begin
                  next_s.led_half = s.led_half + 7'h01;
               end
            end
         endcase
      end else begin
         next_s.led_per = 32'h00000000;
         next_s.led_st = LED_IDLE;
         next_s.led_clk = 1'b0;
         next_s.led_dat = 1'b0;
      end

      // Shared pins follow the swap strap
      if (s.cfg.eeprom_sel) begin
         next_s.pin_clk = s.ee_clk;
         next_s.pin_dat = 1'b0;
         next_s.pin_dat_oe = 1'b0;
      end else begin
         next_s.pin_clk = s.led_clk;
         next_s.pin_dat = s.led_dat;
         next_s.pin_dat_oe = 1'b1;
      end

      // Per-port congestion and retry policy
      limit = s.cfg.collision_retry_sel == 2'h0 ? scd_pkg::COLL_PER_TRY
            : 6'(s.cfg.collision_retry_sel * scd_pkg::COLL_PER_TRY);
      for (int p = 0; p < scd_pkg::NUM_PORTS; p++) begin
         trunk = (p < 2 && s.cfg.trunk_en[0]) || (p >= 6 && s.cfg.trunk_en[1]);
         fdx = trunk | i_full_dup[p];
         fc = fc_on(s.cfg.rmii_pause_policy, trunk, i_partner_pause[p], fdx);
         next_s.port.fc_en[p] = fc;
         next_s.port.skip_poll[p] = trunk | ~s.cfg.poll_partner;
         next_s.port.force_fd100[p] = trunk;
         next_s.port.ign_pause_resume[p] = ~s.cfg.bp_en & ~fdx;
         next_s.port.drop_win[p] = s.cfg.drop_en & (fdx ? ~fc : ~s.cfg.bp_en);
         next_s.port.drop_pkt[p] = 1'b0;
         if (i_tx_done[p]) begin
            next_s.coll_cnt[p] = 6'h00;
         end
         // A collision beside tx_done starts a fresh count for the next packet
         base = i_tx_done[p] ? 6'h00 : s.coll_cnt[p];
         if (i_coll_pulse[p]) begin
            if (!s.cfg.retry_forever && (base + 6'h01) == limit) begin
               next_s.coll_cnt[p] = 6'h00;
               next_s.port.drop_pkt[p] = 1'b1;
            end else begin
               next_s.coll_cnt[p] = base + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s <= '0;
         s.strap <= scd_pkg::STRAP_RST;
         s.cfg <= scd_pkg::CFG_RST;
         s.host_fwd <= scd_pkg::CTRL_RST;
         s.ee_clk <= 1'b1;
         s.led_st <= LED_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign o_wb_ack = s.ack;
   assign o_wb_dat = s.rdat;
   assign o_pin_clk = s.pin_clk;
   assign o_pin_dat = s.pin_dat;
   assign o_pin_dat_oe = s.pin_dat_oe;
   assign o_cfg = s.cfg;
   assign o_cfg_valid = s.captured;
   assign o_bpdu_to_host = s.bpdu_to_host;
   assign o_bpdu_broadcast = s.bpdu_broadcast;
   assign o_port = s.port;

   // EEPROM read data is consumed by the download engine, not here
   logic unused_pin;
   assign unused_pin = i_pin_dat;
endmodule : scd_strap_config_decoder
`default_nettype wire

// >>> tb/scd_checker_asserts.sv
// Concurrent checks on the strap decoder ports
`timescale 1ns/10ps
`default_nettype none
module scd_checker (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Bus
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic o_wb_ack,
   input wire logic [31:0] o_wb_dat,
   // Decoded outputs
   input wire scd_pkg::scd_cfg_t o_cfg,
   input wire logic o_cfg_valid,
   input wire logic o_bpdu_to_host,
   input wire logic o_bpdu_broadcast,
   input wire scd_pkg::scd_port_t o_port,
   input wire logic o_pin_dat_oe
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   logic [7:0] tmask;
   assign tmask = {{2{o_cfg.trunk_en[1]}}, 4'h0, {2{o_cfg.trunk_en[0]}}};
   ack_one_wait_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack not one cycle after request");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held too long");
   dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h00000000)
      else $error("read data outside ack");
   cfg_hold_a: assert property (o_cfg_valid |=> o_cfg_valid && $stable(o_cfg))
      else $error("configuration moved after capture");
   bpdu_host_a: assert property (o_bpdu_to_host [*2] |-> !o_bpdu_broadcast)
      else $error("broadcast while host forward set");
   bpdu_strap_a: assert property ((o_cfg_valid && !o_bpdu_to_host) [*3]
      |-> o_bpdu_broadcast == o_cfg.bpdu_broadcast_sel) else $error("broadcast not strap");
   drop_off_a: assert property ((o_cfg_valid && !o_cfg.drop_en) [*2]
      |-> o_port.drop_win == 8'h00) else $error("drop window while disabled");
   fc_forced_off_a: assert property ((o_cfg_valid && o_cfg.rmii_pause_policy == 2'h2) [*2]
      |-> (o_port.fc_en & ~tmask) == 8'h00) else $error("flow control not off");
   fc_forced_on_a: assert property ((o_cfg_valid && o_cfg.rmii_pause_policy == 2'h1) [*2]
      |-> o_port.fc_en == 8'hFF) else $error("flow control not on");
   trunk_port_a: assert property (o_cfg_valid [*2]
      |-> (o_port.skip_poll & o_port.force_fd100 & tmask) == tmask) else $error("trunk setup");
   ee_release_a: assert property (o_cfg_valid && $past(o_cfg_valid) && o_cfg.eeprom_sel
      |-> !o_pin_dat_oe) else $error("data pin driven in EEPROM mode");
endmodule : scd_checker
bind scd_strap_config_decoder scd_checker u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
   .o_cfg(o_cfg), .o_cfg_valid(o_cfg_valid), .o_bpdu_to_host(o_bpdu_to_host),
   .o_bpdu_broadcast(o_bpdu_broadcast), .o_port(o_port), .o_pin_dat_oe(o_pin_dat_oe));
`default_nettype wire

// >>> tb/scd_board_model.sv
// Board pull resistors, strap drivers and serial LED chain model
`timescale 1ns/10ps
`default_nettype none
module scd_board_model (
   // Clock
   input wire logic i_mclk,
   // Strap drive from bench
   input wire logic [31:0] i_drv_en,
   input wire logic [31:0] i_drv_val,
   output logic [31:0] o_straps,
   // Shared serial pins
   input wire logic i_pin_clk,
   input wire logic i_pin_dat,
   input wire logic i_pin_oe,
   output logic o_pin_line,
   // Observations
   output logic [29:0] o_frame,
   output int o_nbits,
   output int o_bursts,
   output int o_hi_len,
   output int o_period
);
   localparam logic [6:0] EE_DEV_ADDR = 7'h51;
   logic [31:0] en;
   logic clk_q;
   int idle;
   int hi;
   int cyc;
   int start;
   // Reserved straps are never driven
   assign en = i_drv_en & 32'hFFFF00FF;
   // Undriven straps read one
   assign o_straps = (en & i_drv_val) | ~en;
   // Released data line sits at its pull-up
   assign o_pin_line = i_pin_oe ? i_pin_dat : 1'b1;
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      clk_q <= i_pin_clk;
      idle <= i_pin_clk ? 0 : idle + 1;
      hi <= hi + 1;
      if (clk_q && !i_pin_clk) begin
         o_hi_len <= hi;
      end
      if (i_pin_clk && !clk_q) begin
         hi <= 1;
         // Long idle low marks a new burst
         if (idle > 100) begin
            o_frame[0] <= o_pin_line;
            o_nbits <= 1;
            o_bursts <= o_bursts + 1;
            o_period <= cyc - start;
            start <= cyc;
         end else if (o_nbits < 30) begin
            o_frame[o_nbits] <= o_pin_line;
            o_nbits <= o_nbits + 1;
         end
      end
   end
endmodule : scd_board_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the strap configuration decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h00000000;
   logic ack;
   logic [31:0] rdat;
   logic [7:0] link = 8'hA5;
   logic [7:0] evt = 8'hFF;
   logic [7:0] fdx = 8'h3C;
   logic [7:0] pp = 8'h5A;
   logic [7:0] cp = 8'h00;
   logic [7:0] done = 8'h00;
   logic [31:0] drv_en = 32'h00000000;
   logic [31:0] drv_val = 32'h00000000;
   logic [31:0] straps;
   logic pclk, pdat, poe, pline;
   logic [29:0] frame;
   int nbits, bursts, hi_len, period;
   scd_pkg::scd_cfg_t cfg;
   logic cfg_ok, to_host, bcast;
   scd_pkg::scd_port_t prt;
   int n_fail = 0;
   int num_checks = 0;
   int n_drop = 0;
   logic [31:0] r;
   initial begin
      forever #5 clk = ~clk;
   end
   scd_strap_config_decoder #(.LED_PERIOD_NORM(4000), .LED_PERIOD_FAST(3100)) dut (
      .i_mclk(clk), .i_sys_rst(rst), .i_sram_data_bus(straps), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd),
      .o_wb_ack(ack), .o_wb_dat(rdat), .i_link_act(link), .i_rxtx_evt(evt),
      .i_speed100(8'hF0), .i_full_dup(fdx), .i_partner_pause(pp), .i_coll_pulse(cp),
      .i_tx_done(done), .o_pin_clk(pclk), .i_pin_dat(pline), .o_pin_dat(pdat),
      .o_pin_dat_oe(poe), .o_cfg(cfg), .o_cfg_valid(cfg_ok), .o_bpdu_to_host(to_host),
      .o_bpdu_broadcast(bcast), .o_port(prt));
   scd_board_model board (.i_mclk(clk), .i_drv_en(drv_en), .i_drv_val(drv_val),
      .o_straps(straps), .i_pin_clk(pclk), .i_pin_dat(pdat), .i_pin_oe(poe),
      .o_pin_line(pline), .o_frame(frame), .o_nbits(nbits), .o_bursts(bursts),
      .o_hi_len(hi_len), .o_period(period));
   always @(negedge clk) begin
      if (prt.drop_pkt[2] === 1'b1) n_drop++;
   end
   task automatic give_verdict();
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask : chk
   task automatic hang();
      n_fail++;
      give_verdict();
   endtask : hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      // Ack and read data are taken as sampled at the rising edge
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) hang();
   endtask : wb
   task automatic restart(input logic [31:0] en, input logic [31:0] val);
      int n;
      n = 0;
      @(posedge clk);
      rst <= 1'b1;
      drv_en <= en;
      drv_val <= val;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (cfg_ok !== 1'b1 && n < 20);
      if (n >= 20) hang();
      // Port outputs follow the captured straps one cycle later
      @(negedge clk);
   endtask : restart
   task automatic coll(input int n);
      repeat (n) begin
         @(posedge clk);
         cp <= 8'h04;
         @(posedge clk);
         cp <= 8'h00;
      end
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : coll
   task automatic sc_defaults();
      restart(32'h00000000, 32'h00000000);
      chk({cfg.eeprom_sel, cfg.bpdu_broadcast_sel, cfg.led_combine_activity, cfg.drop_en,
         cfg.sram_64k, cfg.init_straps_only, cfg.collision_retry_sel, cfg.trunk_en, cfg.bp_en,
         cfg.rmii_pause_policy, cfg.led_group_enable}, 32'h0000FF3F, "defaults");
      wb(1'b0, 8'h04, 32'h0);
      chk(r, 32'hFFFFFFFF, "strap reg");
      wb(1'b0, 8'h0C, 32'h0);
      chk(r, {4'h0, 8'h95, 8'h62, 3'h4, 4'hA, 5'h1C}, "256K buffers");
      wb(1'b1, 8'h40, 32'hFFFFFFFF);
      wb(1'b0, 8'h40, 32'h0);
      chk(r, 32'h00000000, "unmapped");
      wb(1'b1, 8'h04, 32'h00000000);
      wb(1'b0, 8'h04, 32'h0);
      chk(r, 32'hFFFFFFFF, "strap reg written");
      wb(1'b1, 8'h00, 32'h00000002);
      wb(1'b0, 8'h00, 32'h0);
      chk(r, 32'h00000002, "ctrl readback");
      chk({to_host, bcast}, 32'h2, "bpdu to host");
      wb(1'b1, 8'h00, 32'h00000000);
      repeat (2) @(negedge clk);
      chk({to_host, bcast}, 32'h1, "bpdu broadcast");
   endtask : sc_defaults
   task automatic sc_led();
      int n;
      n = 0;
      @(posedge clk);
      link <= 8'hA5;
      fdx <= 8'h0F;
      pp <= 8'h00;
      // LED mode, speed-up, combine, 128K, trunks, no drop or backpressure, group 1 masked
      restart(32'hFFFFFFFF, 32'hFDB8FFC2);
      chk(cfg.sram_64k, 32'h0, "sram size");
      wb(1'b0, 8'h0C, 32'h0);
      chk(r, {4'h0, 8'h40, 8'h2B, 3'h1, 4'hA, 5'h0F}, "128K buffers");
      chk(bcast, 32'h0, "bpdu dropped");
      chk(prt.skip_poll, 32'hC3, "trunk poll");
      chk(prt.fc_en, 32'hC3, "trunk fc");
      chk(prt.ign_pause_resume, 32'h30, "half duplex ignore");
      do begin
         @(negedge clk);
         n++;
      end while (!(bursts >= 2 && nbits == 30) && n < 12000);
      if (n >= 12000) hang();
      chk(frame, {2'h0, 8'h0F, 12'h000, 8'h5A}, "led frame");
      chk(hi_len, 32'd50, "led clock half");
      chk(period, 32'd3100, "led period");
   endtask : sc_led
   task automatic sc_codes();
      logic [31:0] v;
      logic [7:0] fc;
      int t;
      @(posedge clk);
      fdx <= 8'h3C;
      pp <= 8'h5A;
      for (int k = 3; k >= 0; k--) begin
         v = 32'hFFFFFFFF;
         v[5:4] = k[1:0];
         v[7:6] = k[1:0];
         v[20:19] = k[1:0];
         restart(32'hFFFFFFFF, v);
         fc = (k == 2) ? 8'h00 : ((k == 1) ? 8'hFF : 8'h18);
         chk({cfg.init_straps_only, cfg.init_eeprom, cfg.init_cpu, cfg.speedup},
            {k == 3, k == 2 || k == 0, k == 1, k == 0}, "init code");
         chk({cfg.phy_adv_pause, cfg.poll_partner}, {k != 2, k == 0 || k == 3}, "adv");
         chk(prt.fc_en, fc, "fc enable");
         chk(prt.drop_win, 8'h3C & ~fc, "drop window");
         chk(cfg.retry_forever, k == 1, "retry forever");
         // Past the second fall of the slow clock; the first high half follows reset
         repeat (2000) @(posedge clk);
         @(negedge clk);
         if (k == 2) chk(hi_len, 32'd640, "eeprom clock");
         else if (k == 0) chk(hi_len, 32'd17, "fast eeprom clock");
         else chk(pclk, 32'h1, "clock parked high");
         t = (k == 0) ? 1 : ((k == 1) ? 4 : k);
         coll(15);
         @(posedge clk);
         done <= 8'h04;
         @(posedge clk);
         done <= 8'h00;
         n_drop = 0;
         coll(16 * t - 1);
         chk(n_drop, 32'd0, "early drop");
         coll(1);
         chk(n_drop, k != 1, "drop after tries");
      end
   endtask : sc_codes
   initial begin
      sc_defaults();
      sc_led();
      sc_codes();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
